/* File: dv/sfc_load_model.sv */
// Downstream load model: reads back both outputs, can short them together
`timescale 1ns/100ps
module sfc_load_model (
   input wire logic ref_clk_in,
   input wire logic sso_a_in,
   input wire logic sso_b_in,
   input wire logic short_in,
   output logic [1:0] sense_out
);
   // A cross short makes each pin read high while the other drives high
   wire logic a_wire = short_in ? (sso_a_in | sso_b_in) : sso_a_in;
   wire logic b_wire = short_in ? (sso_a_in | sso_b_in) : sso_b_in;

   // Takes test pulses silently and never adds pulses of its own
   always_ff @(posedge ref_clk_in) begin
      sense_out <= {b_wire, a_wire};
   end
endmodule : sfc_load_model

/* File: dv/sfc_switch_ctrl_tb_top.sv */
// Self-checking testbench of the safety switch output control
`timescale 1ns/100ps
module sfc_switch_ctrl_tb_top;
   import sfc_pkg::*;
   localparam int TL = 8;
   logic ref_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic cen = 1'b1;
   logic ok = 1'b0;
   logic wrong = 1'b0;
   logic border = 1'b0;
   logic fault = 1'b0;
   logic smode = 1'b0;
   logic fb = 1'b1;
   logic shrt = 1'b0;
   logic [1:0] pins = 2'h3;
   logic [1:0] sense;
   logic sa, sb, diag, gr, rd, ye;
   int errors = 0;
   int checked = 0;

   always #2.5 ref_clk_in = ~ref_clk_in;

   sfc_switch_ctrl #(.IN_HOLD(20), .TEST_LEN(TL), .TEST_GAP(100),
      .START_MIN(30), .START_MAX(300), .SLOT(10)) dut_u (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .clk_en_in(cen),
      .actuator_ok_in(ok),
      .actuator_wrong_in(wrong),
      .actuator_border_in(border),
      .fault_in(fault),
      .start_mode_in(smode),
      .safety_pin_in(pins),
      .external_feedback_input_in(fb),
      .sso_sense_in(sense),
      .switched_safety_output_a_out(sa),
      .switched_safety_output_b_out(sb),
      .diag_out(diag),
      .led_green_out(gr),
      .led_red_out(rd),
      .led_yellow_out(ye)
   );

   sfc_load_model load_u (
      .ref_clk_in(ref_clk_in),
      .sso_a_in(sa),
      .sso_b_in(sb),
      .short_in(shrt),
      .sense_out(sense)
   );

   task automatic chk(input string name, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask : chk

   task automatic final_report();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   function automatic logic pick(input int k);
      case (k)
         0: return sa & sb;
         1: return rd;
         2: return ~sa & ~sb;
         3: return ~sa & sb;
         default: return sa & ~sb;
      endcase
   endfunction : pick

   // Bounded wait for a condition; running out ends the run
   task automatic wait_on(input int k, input int n);
      int i;
      for (i = 0; i < n && pick(k) !== 1'b1; i++) begin
         @(negedge ref_clk_in);
      end
      if (pick(k) !== 1'b1) begin
         errors++;
         $display("MISMATCH wait_%0d expected 1 seen 0", k);
         final_report();
      end
   endtask : wait_on

   task automatic do_reset();
      @(negedge ref_clk_in);
      reset_n_in = 1'b0;
      repeat (4) @(negedge ref_clk_in);
      chk("reset_sso", 1'b0, sa | sb);
      chk("reset_lamps", 1'b0, gr | rd | diag);
      reset_n_in = 1'b1;
   endtask : do_reset

   task automatic t_idle();
      repeat (5) @(negedge ref_clk_in);
      chk("idle_yellow", 1'b1, ye);
      chk("idle_rest", 1'b0, gr | rd | diag | sa | sb);
   endtask : t_idle

   task automatic t_auto();
      ok = 1'b1;
      wait_on(0, 60);
      chk("on_green", 1'b1, gr & diag);
      chk("on_other", 1'b0, ye | rd);
      fb = 1'b0;
      wait_on(2, 20);
      fb = 1'b1;
      wait_on(0, 20);
   endtask : t_auto

   task automatic t_glitch();
      pins = 2'h2;
      repeat (10) begin
         @(negedge ref_clk_in);
         chk("glitch_hold", 1'b1, sa | sb);
      end
      pins = 2'h1;
      wait_on(2, 40);
      pins = 2'h3;
      wait_on(0, 40);
   endtask : t_glitch

   task automatic t_selftest();
      int n;
      wait_on(3, 300);
      for (n = 0; n < 20 && sa === 1'b0; n++) begin
         @(negedge ref_clk_in);
      end
      chk("test_len_a", 1'b1, n == TL);
      wait_on(4, 300);
      for (n = 0; n < 20 && sb === 1'b0; n++) begin
         @(negedge ref_clk_in);
      end
      chk("test_len_b", 1'b1, n == TL);
   endtask : t_selftest

   task automatic t_border();
      int n;
      n = 0;
      border = 1'b1;
      repeat (3) @(negedge ref_clk_in);
      repeat (60) begin
         chk("diag_copy", ye, diag);
         chk("border_hold", 1'b1, sa | sb);
         n += int'(ye === 1'b1);
         @(negedge ref_clk_in);
      end
      chk("border_green", 1'b0, gr);
      chk("blink_ratio", 1'b1, n == 30);
      border = 1'b0;
   endtask : t_border

   task automatic t_short();
      shrt = 1'b1;
      wait_on(1, 400);
      chk("err_rest", 1'b0, sa | sb | diag | gr | ye);
      shrt = 1'b0;
   endtask : t_short

   // Start-button mode; len is the button high time in cycles
   task automatic t_start(input int len, input logic good);
      int n;
      n = 0;
      smode = 1'b1;
      fb = 1'b0;
      do_reset();
      repeat (20) @(negedge ref_clk_in);
      repeat (60) begin
         n += int'(gr === 1'b1);
         @(negedge ref_clk_in);
      end
      chk("flash_ratio", 1'b1, n == 10);
      chk("wait_sso", 1'b0, sa | sb);
      fb = 1'b1;
      repeat (len) @(negedge ref_clk_in);
      fb = 1'b0;
      wait_on(good ? 0 : 1, 40);
   endtask : t_start

   // Clock enable low must hold both outputs and the green lamp despite lost inputs
   task automatic t_freeze();
      @(negedge ref_clk_in);
      cen = 1'b0;
      ok = 1'b0;
      pins = 2'h0;
      repeat (30) begin
         @(negedge ref_clk_in);
         chk("freeze_sso", 1'b1, sa & sb);
         chk("freeze_green", 1'b1, gr);
      end
      ok = 1'b1;
      pins = 2'h3;
      cen = 1'b1;
      repeat (5) @(negedge ref_clk_in);
      chk("thaw_sso", 1'b1, sa & sb);
   endtask : t_freeze

   task automatic t_error(input logic use_fault);
      smode = 1'b0;
      fb = 1'b1;
      do_reset();
      wait_on(0, 60);
      wrong = ~use_fault;
      fault = use_fault;
      wait_on(2, 20);
      wait_on(1, 60);
      chk("err_diag", 1'b0, diag | gr);
      wrong = 1'b0;
      fault = 1'b0;
   endtask : t_error

   initial begin
      do_reset();
      t_idle();
      t_auto();
      t_glitch();
      t_selftest();
      t_border();
      t_short();
      t_start(100, 1'b1);
      t_freeze();
      t_start(10, 1'b0);
      smode = 1'b1;
      fb = 1'b0;
      do_reset();
      repeat (20) @(negedge ref_clk_in);
      fb = 1'b1;
      wait_on(1, 400);
      t_error(1'b0);
      t_error(1'b1);
      final_report();
   end
endmodule : sfc_switch_ctrl_tb_top

/* File: pkg/sfc_pkg.sv */
// Shared constants and types of the safety switch output control
// How it works
// - Outputs on only when every condition holds, or while border holds active state
// - Any error, or any lost condition outside border, drops outputs
// - Two inputs, two outputs, one enable decision
// - Input low pulses up to 900 us ignored
// - Output test pulses last at most 0.3 ms
// - Cyclic self-test catches cross shorts
// - Start pulse valid if 30 ms to 5 s
// - Start pulse counts only once inputs ready
// - Diagnosis output copies yellow pulsing
// - Border position reported on diagnosis and lamps
// - Idle: yellow only; active: green and outputs
// - Blink is 1:1, flash is 1:5
// - Border: yellow blinks, outputs hold state
// - Error: red blinks, everything else low
package sfc_pkg;
   localparam int CLK_MHZ = 200;
   localparam int IN_GAP_US = 900;
   localparam int IN_GAP_CYC = IN_GAP_US * CLK_MHZ;
   localparam int TEST_PULSE_US = 300;
   localparam int TEST_PULSE_CYC = TEST_PULSE_US * CLK_MHZ;
   localparam int TEST_GAP_US = 100000;
   localparam int TEST_GAP_CYC = TEST_GAP_US * CLK_MHZ;
   localparam int START_MIN_US = 30000;
   localparam int START_MIN_CYC = START_MIN_US * CLK_MHZ;
   localparam int START_MAX_US = 5000000;
   localparam int START_MAX_CYC = START_MAX_US * CLK_MHZ;
   localparam int SLOT_US = 100000;
   localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
   localparam int PAT_SLOTS = 6;
   localparam int BLINK_SLOTS = 3;
   localparam int FLASH_SLOTS = 1;
   localparam int CNT_W = 32;
   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT_IN, ST_WAIT_START, ST_ACTIVE, ST_ERROR
   } sfc_state_t;
endpackage : sfc_pkg

/* File: src/sfc_in_filter.sv */
// Safety input synchroniser and low-pulse suppressor
`timescale 1ns/100ps
module sfc_in_filter #(
   parameter int HOLD_CYC = sfc_pkg::IN_GAP_CYC
) (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic clk_en_in,
   input wire logic pin_in,
   output logic level_out
);
   import sfc_pkg::*;
   logic s1_q;
   logic s2_q;
   logic level_q;
   logic [CNT_W-1:0] cnt_q;
   wire hold_done = (cnt_q == CNT_W'(HOLD_CYC));

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else if (clk_en_in) begin
         s1_q <= pin_in;
         s2_q <= s1_q;
      end
   end

   // Level drops only after the low outlasts the hold time
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         cnt_q <= '0;
         level_q <= 1'b0;
      end else if (clk_en_in) begin
         if (s2_q) begin
            cnt_q <= '0;
            level_q <= 1'b1;
         end else if (hold_done) begin
            level_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   assign level_out = level_q;

   property p_in_gap;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      $fell(level_q) |-> $past(cnt_q) == CNT_W'(HOLD_CYC) && !$past(s2_q);
   endproperty
   a_in_gap: assert property (p_in_gap)
      else $error("input dropped before hold time");
endmodule : sfc_in_filter

/* File: src/sfc_pattern.sv */
// Blink and flash pattern generator for lamps and diagnosis
`timescale 1ns/100ps
module sfc_pattern #(
   parameter int SLOT = sfc_pkg::SLOT_CYC
) (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic clk_en_in,
   output logic blink_out,
   output logic flash_out
);
   import sfc_pkg::*;
   logic [CNT_W-1:0] cnt_q;
   logic [2:0] slot_q;
   logic blink_q;
   logic flash_q;
   wire slot_end = (cnt_q == CNT_W'(SLOT - 1));
   wire last_slot = (slot_q == 3'(PAT_SLOTS - 1));

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         cnt_q <= '0;
         slot_q <= '0;
         blink_q <= 1'b0;
         flash_q <= 1'b0;
      end else if (clk_en_in) begin
         cnt_q <= slot_end ? '0 : cnt_q + 1'b1;
         if (slot_end) begin
            slot_q <= last_slot ? '0 : slot_q + 1'b1;
         end
         blink_q <= (slot_q < 3'(BLINK_SLOTS));
         flash_q <= (slot_q < 3'(FLASH_SLOTS));
      end
   end

   assign blink_out = blink_q;
   assign flash_out = flash_q;

   property p_flash_in_blink;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      flash_q |-> blink_q;
   endproperty
   a_flash_in_blink: assert property (p_flash_in_blink)
      else $error("flash slot outside blink window");
endmodule : sfc_pattern

/* File: src/sfc_switch_ctrl.sv */
// Safety switch output control: enable decision, self-test, lamps
`timescale 1ns/100ps
module sfc_switch_ctrl #(
   parameter int IN_HOLD = sfc_pkg::IN_GAP_CYC,
   parameter int TEST_LEN = sfc_pkg::TEST_PULSE_CYC,
   parameter int TEST_GAP = sfc_pkg::TEST_GAP_CYC,
   parameter int START_MIN = sfc_pkg::START_MIN_CYC,
   parameter int START_MAX = sfc_pkg::START_MAX_CYC,
   parameter int SLOT = sfc_pkg::SLOT_CYC
) (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic clk_en_in,
   input wire logic actuator_ok_in,
   input wire logic actuator_wrong_in,
   input wire logic actuator_border_in,
   input wire logic fault_in,
   input wire logic start_mode_in,
   input wire logic [1:0] safety_pin_in,
   input wire logic external_feedback_input_in,
   input wire logic [1:0] sso_sense_in,
   output logic switched_safety_output_a_out,
   output logic switched_safety_output_b_out,
   output logic diag_out,
   output logic led_green_out,
   output logic led_red_out,
   output logic led_yellow_out
);
   import sfc_pkg::*;

   sfc_state_t state_q;
   sfc_state_t state_d;
   logic [1:0] in_lvl;
   logic blink;
   logic flash;
   logic fb1_q;
   logic fb2_q;
   logic fb3_q;
   logic [1:0] rb1_q;
   logic [1:0] rb2_q;
   logic [CNT_W-1:0] hi_cnt_q;
   logic armed_q;
   logic [CNT_W-1:0] gap_cnt_q;
   logic [CNT_W-1:0] tcnt_q;
   logic tst_q;
   logic sel_q;
   logic st_fault_q;
   logic sso_a_q;
   logic sso_b_q;
   logic diag_q;
   logic green_q;
   logic red_q;
   logic yellow_q;

   // Both safety inputs, each synchronised and filtered
   for (genvar i = 0; i < 2; i++) begin : g_in
      sfc_in_filter #(
         .HOLD_CYC(IN_HOLD)
      ) u_filt (
         .ref_clk_in(ref_clk_in),
         .reset_n_in(reset_n_in),
         .clk_en_in(clk_en_in),
         .pin_in(safety_pin_in[i]),
         .level_out(in_lvl[i])
      );
   end

   sfc_pattern #(
      .SLOT(SLOT)
   ) u_pat (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .clk_en_in(clk_en_in),
      .blink_out(blink),
      .flash_out(flash)
   );

   // Pin synchronisers for feedback and output readback
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         fb1_q <= 1'b0;
         fb2_q <= 1'b0;
         fb3_q <= 1'b0;
         rb1_q <= '0;
         rb2_q <= '0;
      end else if (clk_en_in) begin
         fb1_q <= external_feedback_input_in;
         fb2_q <= fb1_q;
         fb3_q <= fb2_q;
         rb1_q <= sso_sense_in;
         rb2_q <= rb1_q;
      end
   end

   wire inputs_ok = in_lvl[0] & in_lvl[1];
   wire fb_rise = fb2_q & ~fb3_q;
   wire fb_fall = ~fb2_q & fb3_q;
   wire in_wait_start = (state_q == ST_WAIT_START);
   wire hi_sat = (hi_cnt_q > CNT_W'(START_MAX));
   wire hi_in_range = (hi_cnt_q >= CNT_W'(START_MIN)) && !hi_sat;
   wire start_ok = armed_q & fb_fall & hi_in_range;
   wire start_bad = start_mode_in & armed_q &
      ((fb_fall & ~hi_in_range) | hi_sat);

   // Start button: count high time, armed by a rise while waiting
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         hi_cnt_q <= '0;
         armed_q <= 1'b0;
      end else if (clk_en_in) begin
         if (!fb2_q) begin
            hi_cnt_q <= '0;
         end else if (!hi_sat) begin
            hi_cnt_q <= hi_cnt_q + 1'b1;
         end
         if (!in_wait_start || fb_fall) begin
            armed_q <= 1'b0;
         end else if (fb_rise) begin
            armed_q <= 1'b1;
         end
      end
   end

   wire out_en = (state_q == ST_ACTIVE);
   wire gap_done = (gap_cnt_q == CNT_W'(TEST_GAP - 1));
   wire tst_done = (tcnt_q == CNT_W'(TEST_LEN - 1));
   wire tst_stop = tst_q & (tst_done | ~out_en);
   // The channel under test must read low, the other high
   wire tst_bad = tst_q & tst_done & out_en &
      (rb2_q[sel_q] | ~rb2_q[~sel_q]);

   // Cyclic output self-test, channels taken in turn
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         gap_cnt_q <= '0;
         tcnt_q <= '0;
         tst_q <= 1'b0;
         sel_q <= 1'b0;
         st_fault_q <= 1'b0;
      end else if (clk_en_in) begin
         if (!out_en || tst_q) begin
            gap_cnt_q <= '0;
         end else begin
            gap_cnt_q <= gap_done ? '0 : gap_cnt_q + 1'b1;
         end
         if (tst_stop) begin
            tst_q <= 1'b0;
            sel_q <= ~sel_q;
         end else if (out_en && gap_done) begin
            tst_q <= 1'b1;
         end
         tcnt_q <= tst_q ? tcnt_q + 1'b1 : '0;
         if (tst_bad) begin
            st_fault_q <= 1'b1;
         end
      end
   end

   wire error_now = fault_in | actuator_wrong_in | st_fault_q | start_bad;
   wire fb_met = start_mode_in ? start_ok : fb2_q;

   // Enable decision
   always_comb begin
      state_d = state_q;
      if (state_q == ST_ERROR) begin
         state_d = ST_ERROR;
      end else if (error_now) begin
         state_d = ST_ERROR;
      end else if (actuator_border_in) begin
         state_d = state_q;
      end else if (!actuator_ok_in) begin
         state_d = ST_IDLE;
      end else if (!inputs_ok) begin
         state_d = ST_WAIT_IN;
      end else begin
         unique case (state_q)
            ST_IDLE, ST_WAIT_IN: begin
               state_d = ST_WAIT_START;
            end
            ST_WAIT_START: begin
               if (fb_met) begin
                  state_d = ST_ACTIVE;
               end
            end
            ST_ACTIVE: begin
               if (!start_mode_in && !fb2_q) begin
                  state_d = ST_WAIT_START;
               end
            end
            default: begin
               state_d = ST_ERROR;
            end
         endcase
      end
   end

   wire is_err = (state_q == ST_ERROR);
   wire is_idle = (state_q == ST_IDLE);
   wire border = actuator_border_in & ~is_err;
   wire green_d = ~border & (out_en |
      ((state_q == ST_WAIT_IN) & blink) | (in_wait_start & flash));
   wire yellow_d = border ? blink : is_idle;
   wire red_d = is_err & blink;
   wire diag_d = border ? blink : ~(is_idle | is_err);
   wire sso_a_d = out_en & ~(tst_q & ~sel_q);
   wire sso_b_d = out_en & ~(tst_q & sel_q);

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         state_q <= ST_IDLE;
         sso_a_q <= 1'b0;
         sso_b_q <= 1'b0;
         diag_q <= 1'b0;
         green_q <= 1'b0;
         red_q <= 1'b0;
         yellow_q <= 1'b0;
      end else if (clk_en_in) begin
         state_q <= state_d;
         sso_a_q <= sso_a_d;
         sso_b_q <= sso_b_d;
         diag_q <= diag_d;
         green_q <= green_d;
         red_q <= red_d;
         yellow_q <= yellow_d;
      end
   end

   assign switched_safety_output_a_out = sso_a_q;
   assign switched_safety_output_b_out = sso_b_q;
   assign diag_out = diag_q;
   assign led_green_out = green_q;
   assign led_red_out = red_q;
   assign led_yellow_out = yellow_q;

   property p_off_unless_active;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      clk_en_in && state_q != ST_ACTIVE |=> !sso_a_q && !sso_b_q;
   endproperty
   a_off_unless_active: assert property (p_off_unless_active)
      else $error("output on outside active state");

   property p_drop_on_loss;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      clk_en_in && out_en && !actuator_border_in &&
      (!inputs_ok || !actuator_ok_in || error_now)
      |=> state_q != ST_ACTIVE ##1 !sso_a_q && !sso_b_q;
   endproperty
   a_drop_on_loss: assert property (p_drop_on_loss)
      else $error("outputs kept after lost condition");

   property p_same_enable;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      clk_en_in && !tst_q |=> sso_a_q == sso_b_q;
   endproperty
   a_same_enable: assert property (p_same_enable)
      else $error("output channels differ outside test");

   property p_test_len;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      tst_q |-> tcnt_q < CNT_W'(TEST_LEN);
   endproperty
   a_test_len: assert property (p_test_len)
      else $error("test pulse too long");

   property p_test_fault;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      clk_en_in && tst_bad ##1 clk_en_in |=> is_err;
   endproperty
   a_test_fault: assert property (p_test_fault)
      else $error("failed self-test did not force error");

   property p_start_window;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      $rose(state_q == ST_ACTIVE) && start_mode_in && $past(in_wait_start)
      |-> $past(hi_cnt_q) >= CNT_W'(START_MIN) &&
          $past(hi_cnt_q) <= CNT_W'(START_MAX);
   endproperty
   a_start_window: assert property (p_start_window)
      else $error("start pulse outside window accepted");

   property p_idle_lamps;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      clk_en_in && is_idle && !actuator_border_in
      |=> yellow_q && !green_q && !diag_q && !sso_a_q;
   endproperty
   a_idle_lamps: assert property (p_idle_lamps)
      else $error("wrong idle indication");

   property p_diag_yellow;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      clk_en_in && border |=> diag_q == yellow_q && !green_q;
   endproperty
   a_diag_yellow: assert property (p_diag_yellow)
      else $error("diagnosis differs from yellow at border");

   property p_error_lamps;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      clk_en_in && is_err |=> red_q == $past(blink) && !green_q &&
         !yellow_q && !diag_q;
   endproperty
   a_error_lamps: assert property (p_error_lamps)
      else $error("wrong error indication");

   property p_border_hold;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      clk_en_in && border && !error_now |=> state_q == $past(state_q);
   endproperty
   a_border_hold: assert property (p_border_hold)
      else $error("state moved while actuator at border");
endmodule : sfc_switch_ctrl
